//--- rst_pd_monitor.sv
// Shared constants of the command controller, and the reset/power-down pin monitor.
// Assumes the master clock runs the monitor and the pin is asynchronous to it.
package adc_cmd_pkg;
   // Command opcodes; the low bit is ignored where marked as a pair
   localparam logic [7:0] OP_NOP         = 8'h00;
   localparam logic [7:0] OP_RESET       = 8'h06;
   localparam logic [7:0] OP_MAIN_START  = 8'h08;
   localparam logic [7:0] OP_MAIN_STOP   = 8'h0a;
   localparam logic [7:0] OP_AUX_START   = 8'h0c;
   localparam logic [7:0] OP_AUX_STOP    = 8'h0e;
   localparam logic [7:0] OP_MAIN_READ   = 8'h12;
   localparam logic [7:0] OP_AUX_READ    = 8'h14;
   localparam logic [7:0] OP_MAIN_SYS_OFS = 8'h16;
   localparam logic [7:0] OP_MAIN_SYS_GAIN = 8'h17;
   localparam logic [7:0] OP_MAIN_SELF_OFS = 8'h19;
   localparam logic [7:0] OP_AUX_SYS_OFS  = 8'h1b;
   localparam logic [7:0] OP_AUX_SYS_GAIN = 8'h1c;
   localparam logic [7:0] OP_AUX_SELF_OFS = 8'h1e;
   localparam logic [2:0] PFX_REG_READ   = 3'h1;
   localparam logic [2:0] PFX_REG_WRITE  = 3'h2;
   // Calibration strobe positions
   localparam int CAL_MAIN_SYS_OFS  = 0;
   localparam int CAL_MAIN_SYS_GAIN = 1;
   localparam int CAL_MAIN_SELF_OFS = 2;
   localparam int CAL_AUX_SYS_OFS   = 3;
   localparam int CAL_AUX_SYS_GAIN  = 4;
   localparam int CAL_AUX_SELF_OFS  = 5;
   // Register file
   localparam int         REG_COUNT      = 27;
   localparam logic [5:0] ADDR_ID        = 6'h00;
   localparam logic [5:0] ADDR_POWER     = 6'h01;
   localparam logic [5:0] ADDR_MODE0     = 6'h03;
   localparam logic [5:0] ADDR_MODE1     = 6'h04;
   localparam logic [5:0] ADDR_LIMIT     = 6'h1b;
   localparam int         RESET_FLAG_BIT = 4;
   localparam int         STATUS_RST_BIT = 0;
   localparam int         CHOP_EN_BIT    = 4;
   localparam int         DELAY_LSB      = 0;
   localparam int         FILTER_LSB     = 5;
   // Identification value is arbitrary
   localparam logic [7:0] DEVICE_ID_VALUE = 8'h5a;
   localparam logic [7:0] REG_DEF [REG_COUNT] = '{
      DEVICE_ID_VALUE, 8'h11, 8'h05, 8'h00, 8'h80, 8'h04, 8'h01, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   // Pin timing in master clock cycles
   localparam int PD_HOLD_CYCLES = 65536;
   localparam int RST_MIN_CYCLES = 4;
   localparam int LOW_CNT_W      = 18;
   // Command state machine
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_COUNT = 2'b01,
      ST_DATA  = 2'b11
   } cmd_state_e;
endpackage

`timescale 1ns/10ps
module rst_pd_monitor
   import adc_cmd_pkg::*;
#(
   parameter int PD_HOLD = PD_HOLD_CYCLES
)
(
   // Clock and reset
   input  wire logic clk_sys_in,
   input  wire logic sys_rst_in,
   // Pin, active low
   input  wire logic reset_powerdown_pin_n_in,
   // Results
   output logic      pin_reset_out,
   output logic      powerdown_out
);
   logic                 pin_s1_q;
   logic                 pin_s2_q;
   logic                 pin_s3_q;
   logic [LOW_CNT_W-1:0] low_cnt_q;
   logic [LOW_CNT_W-1:0] low_cnt_d;
   wire                  rise_w    = pin_s2_q & ~pin_s3_q;
   wire                  long_w    = low_cnt_q >= LOW_CNT_W'(PD_HOLD);
   wire                  enough_w  = low_cnt_q >= LOW_CNT_W'(RST_MIN_CYCLES);

   // Count low cycles, saturating at the power-down threshold
   assign low_cnt_d = pin_s2_q ? '0 : (long_w ? low_cnt_q : low_cnt_q + 1'b1); // RQ24

   always_ff @(posedge clk_sys_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         pin_s1_q      <= 1'b1;
         pin_s2_q      <= 1'b1;
         pin_s3_q      <= 1'b1;
         low_cnt_q     <= '0;
         pin_reset_out <= 1'b0;
         powerdown_out <= 1'b0;
      end
      else
      begin
         pin_s1_q      <= reset_powerdown_pin_n_in;
         pin_s2_q      <= pin_s1_q;
         pin_s3_q      <= pin_s2_q;
         low_cnt_q     <= low_cnt_d;
         pin_reset_out <= rise_w & (enough_w | powerdown_out); // RQ4 RQ6
         powerdown_out <= pin_s2_q ? 1'b0 : (powerdown_out | long_w); // RQ4
      end
   end
endmodule // rst_pd_monitor

//--- adc_cmd_ctl.sv
// Command interpreter, register file, reset/power-down and chop sequencing.
// Assumes a serial host on sclk_in with chip select, and a filter on the master clock.
// Summary of operation
// [RQ1] Reset opcode restarts operation and returns all registers to defaults.
// [RQ2] Host raises chip select before sending the reset opcode.
// [RQ3] Host waits eight master clocks after reset opcode before next command.
// [RQ4] Short low pulse on pin resets; held past 65536 cycles powers down.
// [RQ5] Power-down turns off converter and reference; digital outputs stay driven.
// [RQ6] Leaving power-down performs a full reset with register defaults.
// [RQ7] Host waits 65536 cycles after power-down exit before communicating.
// [RQ8] Chop alternates input polarity; output is half the polarity difference.
// [RQ9] First chop conversion gives no output; each later one pairs with previous.
// [RQ10] Chop output rate drops by filter settling and programmed delay.
// [RQ11] Commands accepted whether conversions run or are stopped.
// [RQ12] New data not loaded to output shifter during register read/write.
// [RQ13] Chip select low for whole command; raising it aborts the command.
// [RQ14] Host sends only defined opcodes.
// [RQ15] No-operation opcode does nothing; host holds data input low.
// [RQ16] Start/stop opcodes for main and auxiliary converter, low bit ignored.
// [RQ17] Data read opcodes for main and auxiliary converter, low bit ignored.
// [RQ18] Main calibration opcodes: system offset, system gain, self offset.
// [RQ19] Auxiliary calibration opcodes: system offset, system gain, self offset.
// [RQ20] Register read/write: prefix plus address byte, then count-minus-one byte.
// [RQ21] Any reset sets the reset flag; cleared only by writing zero.
// [RQ22] Pin reset needs the pin low at least four master clocks.
// [RQ23] Undefined opcodes affect neither registers nor conversions.
// [RQ24] Low time on the pin is counted to pick reset or power-down.
`timescale 1ns/10ps
module adc_cmd_ctl
   import adc_cmd_pkg::*;
#(
   parameter int PD_HOLD = PD_HOLD_CYCLES
)
(
   // Master clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        sys_rst_in,
   // Serial link
   input  wire logic        sclk_in,
   input  wire logic        cs_n_in,
   input  wire logic        din_in,
   output logic             dout_out,
   // Reset/power-down pin, active low
   input  wire logic        reset_powerdown_pin_n_in,
   // Filter side
   input  wire logic        main_raw_valid_in,
   input  wire logic [31:0] main_raw_in,
   input  wire logic        aux_valid_in,
   input  wire logic [31:0] aux_data_in,
   // Control outputs
   output logic             main_run_out,
   output logic             aux_run_out,
   output logic             analog_enable_out,
   output logic             ref_enable_out,
   output logic             chop_polarity_out,
   output logic             filter_restart_out,
   output logic [3:0]       settle_delay_out,
   output logic [2:0]       filter_mode_out,
   output logic             main_data_ready_out,
   output logic [31:0]      main_data_out,
   output logic [5:0]       cal_strobe_out
);
   // Link domain
   logic       link_rst;
   logic [2:0] bit_cnt_q;
   logic [6:0] rx_sh_q;
   logic [7:0] tx_sh_q;
   logic [7:0] rx_byte_q;
   logic       rx_tgl_q;
   logic [7:0] tx_byte;

   assign link_rst = cs_n_in | sys_rst_in;

   // Sample data input on falling edge; chip select high aborts the byte
   always_ff @(negedge sclk_in or posedge link_rst)
   begin
      if (link_rst)
      begin
         bit_cnt_q <= '0; // RQ13
         rx_sh_q   <= '0;
      end
      else
      begin
         bit_cnt_q <= bit_cnt_q + 1'b1;
         rx_sh_q   <= {rx_sh_q[5:0], din_in};
      end
   end

   // Completed byte and its toggle event
   always_ff @(negedge sclk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         rx_byte_q <= '0;
         rx_tgl_q  <= 1'b0;
      end
      else if (!cs_n_in && bit_cnt_q == 3'h7)
      begin
         rx_byte_q <= {rx_sh_q, din_in};
         rx_tgl_q  <= ~rx_tgl_q;
      end
   end

   // Shift out on rising edge; a new byte is taken at each byte start
   always_ff @(posedge sclk_in or posedge link_rst)
   begin
      if (link_rst)
      begin
         tx_sh_q  <= '0;
         dout_out <= 1'b0;
      end
      else if (bit_cnt_q == 3'h0)
      begin
         tx_sh_q  <= {tx_byte[6:0], 1'b0};
         dout_out <= tx_byte[7];
      end
      else
      begin
         tx_sh_q  <= {tx_sh_q[6:0], 1'b0};
         dout_out <= tx_sh_q[7];
      end
   end

   // Master clock domain: crossings
   logic tgl_s1_q;
   logic tgl_s2_q;
   logic tgl_s3_q;
   logic cs_s1_q;
   logic cs_s2_q;
   wire  byte_evt = tgl_s2_q ^ tgl_s3_q;
   wire  cs_high  = cs_s2_q;

   always_ff @(posedge clk_sys_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         tgl_s1_q <= 1'b0;
         tgl_s2_q <= 1'b0;
         tgl_s3_q <= 1'b0;
         cs_s1_q  <= 1'b1;
         cs_s2_q  <= 1'b1;
      end
      else
      begin
         tgl_s1_q <= rx_tgl_q;
         tgl_s2_q <= tgl_s1_q;
         tgl_s3_q <= tgl_s2_q;
         cs_s1_q  <= cs_n_in;
         cs_s2_q  <= cs_s1_q;
      end
   end

   // Pin monitor
   logic pin_reset;
   logic powerdown;

   rst_pd_monitor #(
      .PD_HOLD                  (PD_HOLD)
   ) u_pin (
      .clk_sys_in               (clk_sys_in),
      .sys_rst_in               (sys_rst_in),
      .reset_powerdown_pin_n_in (reset_powerdown_pin_n_in),
      .pin_reset_out            (pin_reset),
      .powerdown_out            (powerdown)
   );

   // Command decode
   logic [7:0]  rx_byte;
   cmd_state_e  state_q;
   cmd_state_e  state_d;
   logic        is_write_q;
   logic [5:0]  addr_q;
   logic [4:0]  cnt_q;
   logic [7:0]  regs_q [REG_COUNT];
   logic [39:0] txbuf_q;
   logic [39:0] txbuf_d;
   logic [31:0] main_result_q;
   logic        main_valid_q;
   logic [31:0] aux_hold_q;

   assign rx_byte = rx_byte_q;
   wire idle_byte    = byte_evt & ~cs_high & state_q == ST_IDLE;
   wire op_reset     = idle_byte & rx_byte[7:1] == OP_RESET[7:1]; // RQ1
   wire op_main_on   = idle_byte & rx_byte[7:1] == OP_MAIN_START[7:1]; // RQ16
   wire op_main_off  = idle_byte & rx_byte[7:1] == OP_MAIN_STOP[7:1]; // RQ16
   wire op_aux_on    = idle_byte & rx_byte[7:1] == OP_AUX_START[7:1]; // RQ16
   wire op_aux_off   = idle_byte & rx_byte[7:1] == OP_AUX_STOP[7:1]; // RQ16
   wire op_main_rd   = idle_byte & rx_byte[7:1] == OP_MAIN_READ[7:1]; // RQ17
   wire op_aux_rd    = idle_byte & rx_byte[7:1] == OP_AUX_READ[7:1]; // RQ17
   wire op_reg       = idle_byte & (rx_byte[7:5] == PFX_REG_READ
                                  | rx_byte[7:5] == PFX_REG_WRITE); // RQ20
   wire [5:0] cal_hit = {rx_byte == OP_AUX_SELF_OFS, rx_byte == OP_AUX_SYS_GAIN,
                         rx_byte == OP_AUX_SYS_OFS, rx_byte == OP_MAIN_SELF_OFS,
                         rx_byte == OP_MAIN_SYS_GAIN, rx_byte == OP_MAIN_SYS_OFS}; // RQ18 RQ19
   // NOP and undefined opcodes match nothing above and have no effect: RQ15 RQ23

   wire soft_clr   = op_reset | pin_reset | powerdown; // RQ1 RQ6
   wire data_byte  = byte_evt & ~cs_high & state_q == ST_DATA;
   wire last_byte  = cnt_q == 5'h00;
   wire in_range   = addr_q < ADDR_LIMIT;
   wire [7:0] rd_val = in_range ? regs_q[addr_q[4:0]] : 8'h00;
   wire [7:0] status = {7'h00, regs_q[ADDR_POWER[4:0]][RESET_FLAG_BIT]}; // RQ21
   wire [7:0] nxt_rd = (addr_q + 6'h01) < ADDR_LIMIT ? regs_q[5'(addr_q + 6'h01)] : 8'h00;

   always_comb
   begin
      state_d = state_q;
      if (cs_high)
         state_d = ST_IDLE; // RQ13
      else if (op_reg)
         state_d = ST_COUNT;
      else if (byte_evt && state_q == ST_COUNT)
         state_d = ST_DATA;
      else if (data_byte && last_byte)
         state_d = ST_IDLE;
   end

   assign tx_byte = txbuf_q[39:32];

   // Output buffer: register bytes, status plus data, or new conversion data
   always_comb
   begin
      txbuf_d = txbuf_q;
      if (byte_evt)
         txbuf_d = {txbuf_q[31:0], 8'h00};
      if (op_main_rd)
         txbuf_d = {status, main_data_out};
      else if (op_aux_rd)
         txbuf_d = {status, aux_hold_q};
      else if (byte_evt && state_q == ST_COUNT && !is_write_q)
         txbuf_d = {rd_val, 32'h0};
      else if (data_byte && !is_write_q)
         txbuf_d = {nxt_rd, 32'h0};
      else if (main_valid_q && state_q == ST_IDLE)
         txbuf_d = {status, main_result_q}; // RQ12
   end

   always_ff @(posedge clk_sys_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         state_q    <= ST_IDLE;
         is_write_q <= 1'b0;
         addr_q     <= '0;
         cnt_q      <= '0;
         txbuf_q    <= '0;
      end
      else if (soft_clr)
      begin
         state_q    <= ST_IDLE;
         is_write_q <= 1'b0;
         addr_q     <= '0;
         cnt_q      <= '0;
         txbuf_q    <= '0;
      end
      else
      begin
         state_q <= state_d; // RQ11
         txbuf_q <= txbuf_d;
         if (op_reg)
         begin
            is_write_q <= rx_byte[7:5] == PFX_REG_WRITE;
            addr_q     <= {1'b0, rx_byte[4:0]};
         end
         if (byte_evt && state_q == ST_COUNT)
            cnt_q <= rx_byte[4:0]; // RQ20
         if (data_byte)
         begin
            cnt_q  <= cnt_q - 5'h01;
            addr_q <= in_range ? addr_q + 6'h01 : addr_q;
         end
      end
   end

   // Register file with defaults restored on every reset
   genvar gi;
   generate
      for (gi = 0; gi < REG_COUNT; gi++)
      begin : g_reg
         wire we = data_byte & is_write_q & addr_q == 6'(gi) & gi != 0;
         always_ff @(posedge clk_sys_in or posedge sys_rst_in)
         begin
            if (sys_rst_in)
               regs_q[gi] <= REG_DEF[gi];
            else if (soft_clr)
               regs_q[gi] <= REG_DEF[gi]; // RQ1 RQ6 RQ21
            else if (we)
               regs_q[gi] <= rx_byte;
         end
      end
   endgenerate

   // Converter run control, calibration strobes and power state
   always_ff @(posedge clk_sys_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         main_run_out      <= 1'b0;
         aux_run_out       <= 1'b0;
         cal_strobe_out    <= '0;
         analog_enable_out <= 1'b1;
         ref_enable_out    <= 1'b1;
         settle_delay_out  <= '0;
         filter_mode_out   <= '0;
      end
      else
      begin
         main_run_out      <= ~soft_clr & (op_main_on | main_run_out & ~op_main_off);
         aux_run_out       <= ~soft_clr & (op_aux_on | aux_run_out & ~op_aux_off);
         cal_strobe_out    <= idle_byte ? cal_hit : 6'h00;
         analog_enable_out <= ~powerdown; // RQ5
         ref_enable_out    <= ~powerdown; // RQ5
         settle_delay_out  <= regs_q[ADDR_MODE0[4:0]][DELAY_LSB +: 4]; // RQ10
         filter_mode_out   <= regs_q[ADDR_MODE1[4:0]][FILTER_LSB +: 3]; // RQ10
      end
   end

   // Chop sequencing and result formation
   logic        chop_en;
   logic        have_prev_q;
   logic [31:0] prev_q;
   logic [32:0] diff;
   logic [31:0] chop_res;

   assign chop_en  = regs_q[ADDR_MODE0[4:0]][CHOP_EN_BIT];
   assign diff     = chop_polarity_out ? {prev_q[31], prev_q} - {main_raw_in[31], main_raw_in}
                                       : {main_raw_in[31], main_raw_in} - {prev_q[31], prev_q};
   assign chop_res = diff[32:1]; // RQ8
   wire conv_evt   = main_raw_valid_in & main_run_out;
   wire chop_step  = conv_evt & chop_en;

   always_ff @(posedge clk_sys_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         have_prev_q        <= 1'b0;
         prev_q             <= '0;
         chop_polarity_out  <= 1'b0;
         filter_restart_out <= 1'b0;
         main_result_q      <= '0;
         main_valid_q       <= 1'b0;
         aux_hold_q         <= '0;
      end
      else if (soft_clr || !chop_en || !main_run_out)
      begin
         have_prev_q        <= 1'b0;
         chop_polarity_out  <= 1'b0;
         filter_restart_out <= 1'b0;
         main_valid_q       <= conv_evt & ~soft_clr;
         main_result_q      <= conv_evt & ~soft_clr ? main_raw_in : main_result_q;
         aux_hold_q         <= soft_clr ? 32'h0 : (aux_valid_in ? aux_data_in : aux_hold_q);
      end
      else
      begin
         have_prev_q        <= have_prev_q | chop_step;
         prev_q             <= chop_step ? main_raw_in : prev_q;
         chop_polarity_out  <= chop_polarity_out ^ chop_step; // RQ8
         filter_restart_out <= chop_step; // RQ10
         main_valid_q       <= chop_step & have_prev_q; // RQ9
         main_result_q      <= chop_step & have_prev_q ? chop_res : main_result_q; // RQ9
         aux_hold_q         <= aux_valid_in ? aux_data_in : aux_hold_q;
      end
   end

   always_ff @(posedge clk_sys_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         main_data_ready_out <= 1'b0;
         main_data_out       <= '0;
      end
      else
      begin
         main_data_ready_out <= main_valid_q;
         main_data_out       <= main_valid_q ? main_result_q : main_data_out;
      end
   end
endmodule // adc_cmd_ctl

//--- adc_cmd_ctl_assertions.sv
// Concurrent checks on the ports of the command controller.
// Assumes it is bound to adc_cmd_ctl and shares its PD_HOLD value.
`timescale 1ns/10ps
module adc_cmd_ctl_assertions
#(
   parameter int PD_HOLD = 64
)
(
   // Clock and reset
   input  wire logic       clk_sys_in,
   input  wire logic       sys_rst_in,
   // Observed ports
   input  wire logic       cs_n_in,
   input  wire logic       dout_out,
   input  wire logic       reset_powerdown_pin_n_in,
   input  wire logic       main_raw_valid_in,
   input  wire logic       main_run_out,
   input  wire logic       analog_enable_out,
   input  wire logic       ref_enable_out,
   input  wire logic       filter_restart_out,
   input  wire logic       main_data_ready_out,
   input  wire logic [5:0] cal_strobe_out
);
   int   low_cnt_q;
   logic take_w;

   assign take_w = main_raw_valid_in & main_run_out;

   // Cycles the pin has been low
   always_ff @(posedge clk_sys_in or posedge sys_rst_in)
      if (sys_rst_in)
         low_cnt_q <= 0;
      else
         low_cnt_q <= reset_powerdown_pin_n_in ? 0 : low_cnt_q + 1;

   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);

   sequence s_pd_released;
      !analog_enable_out ##1 reset_powerdown_pin_n_in [*2];
   endsequence
   sequence s_strobe;
      cal_strobe_out != 6'h00;
   endsequence

   a_pd_refs_off: assert property (!analog_enable_out |-> !ref_enable_out)
      else $error("reference on while converter off");
   a_pd_runs_off: assert property (!analog_enable_out |-> !main_run_out && !main_data_ready_out)
      else $error("conversion activity in power-down");
   a_pd_long_hold: assert property (low_cnt_q > PD_HOLD + 8 |-> !analog_enable_out)
      else $error("long low pin did not power down");
   a_pd_needs_hold: assert property ($fell(analog_enable_out) |-> low_cnt_q >= PD_HOLD)
      else $error("power-down entered too early");
   a_pd_exit_wake: assert property (s_pd_released |-> ##[1:20] analog_enable_out)
      else $error("power-down not left after pin rise");
   a_ready_cause: assert property (main_data_ready_out |-> $past(take_w, 2))
      else $error("result without a conversion two cycles before");
   a_strobe_one_pulse: assert property (s_strobe |-> $onehot(cal_strobe_out) ##1 !cal_strobe_out)
      else $error("calibration strobe not a single one-cycle bit");
   a_restart_pulse: assert property (filter_restart_out |=> !filter_restart_out)
      else $error("filter restart longer than one cycle");
   a_dout_quiet: assert property (cs_n_in [*2] |-> !dout_out)
      else $error("data out not driven low while deselected");
endmodule // adc_cmd_ctl_assertions

bind adc_cmd_ctl adc_cmd_ctl_assertions #(.PD_HOLD(PD_HOLD)) i_chk (.clk_sys_in(clk_sys_in),
   .sys_rst_in(sys_rst_in), .cs_n_in(cs_n_in), .dout_out(dout_out),
   .reset_powerdown_pin_n_in(reset_powerdown_pin_n_in), .main_raw_valid_in(main_raw_valid_in),
   .main_run_out(main_run_out), .analog_enable_out(analog_enable_out),
   .ref_enable_out(ref_enable_out), .filter_restart_out(filter_restart_out),
   .main_data_ready_out(main_data_ready_out), .cal_strobe_out(cal_strobe_out));

//--- serial_host_model.sv
// Host side of the serial link and of the reset/power-down pin.
// Assumes the device takes din on falling sclk and shifts dout on rising sclk.
`timescale 1ns/10ps
module serial_host_model
(
   // Link
   output logic      sclk_out,
   output logic      cs_n_out,
   output logic      din_out,
   input  wire logic dout_in,
   // Pin, active low
   output logic      pin_n_out
);
   initial
   begin
      sclk_out  = 1'b0;
      cs_n_out  = 1'b1;
      din_out   = 1'b0;
      pin_n_out = 1'b1;
   end

   // One byte, 12 ns link clock; clock stands low between bytes
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         #3 din_out <= tx[i];
         #3 sclk_out <= 1'b1;
         #6 rx[i] = dout_in;
         sclk_out <= 1'b0;
      end
      #80; // inter-byte gap
   endtask

   // Whole command under one chip-select low
   task automatic frame(input int n, input logic [7:0] tx [6], output logic [7:0] rx [6]);
      cs_n_out <= 1'b0;
      #20;
      for (int k = 0; k < n; k++)
         xfer(tx[k], rx[k]);
      cs_n_out <= 1'b1;
      din_out  <= ~din_out;
      #100;
   endtask

   task automatic set_pin(input logic lvl);
      pin_n_out <= lvl;
   endtask
endmodule // serial_host_model

//--- test_adc_command_reset_chop_control.sv
// Self-checking bench for the command controller.
// Assumes adc_cmd_pkg and serial_host_model are compiled first.
`timescale 1ns/10ps
module test_adc_command_reset_chop_control;
   import adc_cmd_pkg::*;
   localparam int PD = 64;
   logic        clk_sys_in, sys_rst_in, sclk, cs_n, din, dout, pin_n;
   logic        raw_valid, aux_valid, main_run, aux_run, ana_en, ref_en, pol, restart, ready;
   logic [31:0] raw, aux_data, data;
   logic [3:0]  delay;
   logic [2:0]  fmode;
   logic [5:0]  cal, cal_seen;
   logic [7:0]  rx [6];
   int          err_total, n_checks, n_ready, n_restart;

   serial_host_model i_host (.sclk_out(sclk), .cs_n_out(cs_n), .din_out(din), .dout_in(dout),
      .pin_n_out(pin_n));
   adc_cmd_ctl #(.PD_HOLD(PD)) i_dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
      .sclk_in(sclk), .cs_n_in(cs_n), .din_in(din), .dout_out(dout),
      .reset_powerdown_pin_n_in(pin_n), .main_raw_valid_in(raw_valid), .main_raw_in(raw),
      .aux_valid_in(aux_valid), .aux_data_in(aux_data), .main_run_out(main_run),
      .aux_run_out(aux_run), .analog_enable_out(ana_en), .ref_enable_out(ref_en),
      .chop_polarity_out(pol), .filter_restart_out(restart), .settle_delay_out(delay),
      .filter_mode_out(fmode), .main_data_ready_out(ready), .main_data_out(data),
      .cal_strobe_out(cal));

   initial
   begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end

   // Pulse collectors
   always @(posedge clk_sys_in)
   begin
      cal_seen  <= cal_seen | cal;
      n_ready   <= n_ready + ready;
      n_restart <= n_restart + restart;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_sys_in);
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic hframe(input int n, input logic [7:0] tx [6]);
      i_host.frame(n, tx, rx);
   endtask

   task automatic cmd1(input logic [7:0] op);
      hframe(1, '{op, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
   endtask

   task automatic register_write_cmd(input logic [4:0] a, input logic [7:0] v);
      hframe(3, '{{PFX_REG_WRITE, a}, 8'h00, v, 8'h00, 8'h00, 8'h00});
   endtask

   task automatic conv(input logic [31:0] v);
      @(posedge clk_sys_in);
      raw_valid <= 1'b1;
      raw       <= v;
      @(posedge clk_sys_in);
      raw_valid <= 1'b0;
      wait_clk(6);
   endtask

   task automatic t_reg_read;
      hframe(4, '{{PFX_REG_READ, 5'h01}, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00});
      check("power default", REG_DEF[1], rx[2]);
      check("second register", REG_DEF[2], rx[3]);
      check("filter mode", REG_DEF[4][7:5], fmode);
      hframe(4, '{{PFX_REG_READ, 5'h1a}, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00});
      check("last register", REG_DEF[26], rx[2]);
      check("beyond last", 8'h00, rx[3]);
   endtask

   task automatic t_run_cmds;
      logic [7:0] op;
      for (int i = 8; i < 16; i++)
      begin
         op = 8'(i);
         cmd1(op);
         check("main run", op[3:1] == 3'b100, main_run);
         check("aux run", op[3:1] == 3'b110, aux_run);
      end
   endtask

   task automatic t_cal_cmds;
      logic [7:0] ops [12] = '{OP_MAIN_SYS_OFS, OP_MAIN_SYS_GAIN, OP_MAIN_SELF_OFS,
         OP_AUX_SYS_OFS, OP_AUX_SYS_GAIN, OP_AUX_SELF_OFS, OP_NOP, 8'h18, 8'h1a, 8'h1d,
         8'h1f, 8'h01};
      for (int k = 0; k < 12; k++)
      begin
         cal_seen = 6'h00;
         cmd1(ops[k]);
         check("cal strobe", (k < 6) ? 6'(1 << k) : 6'h00, cal_seen);
         check("run unchanged", 0, main_run);
      end
   endtask

   task automatic t_chop;
      register_write_cmd(ADDR_MODE0[4:0], 8'h14);
      check("settle delay", 4'h4, delay);
      cmd1(OP_MAIN_START);
      n_ready   = 0;
      n_restart = 0;
      conv(32'd100);
      check("first withheld", 0, n_ready);
      check("reversed polarity", 1, pol);
      conv(32'd40);
      check("pair result", 32'd30, data);
      conv(32'd20);
      check("next pair", 32'hfffffff6, data);
      check("result count", 2, n_ready);
      check("restart count", 3, n_restart);
      hframe(6, '{8'h13, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
      check("status flag", 1, rx[1][STATUS_RST_BIT]);
      check("read data", 32'hfffffff6, {rx[2], rx[3], rx[4], rx[5]});
      @(posedge clk_sys_in);
      {aux_valid, aux_data} <= {1'b1, 32'h5eed0042};
      @(posedge clk_sys_in);
      aux_valid <= 1'b0;
      hframe(6, '{8'h15, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
      check("aux read", 32'h5eed0042, {rx[2], rx[3], rx[4], rx[5]});
   endtask

   task automatic t_cmd_reset;
      for (int k = 6; k < 8; k++)
      begin
         cmd1(OP_MAIN_START);
         register_write_cmd(ADDR_MODE0[4:0], 8'h14);
         register_write_cmd(ADDR_POWER[4:0], 8'h01);
         hframe(3, '{{PFX_REG_READ, 5'h01}, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
         check("flag cleared", 8'h01, rx[2]);
         cmd1(8'(k));
         check("run after reset", 0, main_run);
         check("delay after reset", REG_DEF[3][3:0], delay);
         hframe(3, '{{PFX_REG_READ, 5'h01}, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
         check("flag set", REG_DEF[1], rx[2]);
      end
   endtask

   task automatic t_pin;
      cmd1(OP_MAIN_START);
      i_host.set_pin(1'b0);
      wait_clk(10);
      i_host.set_pin(1'b1);
      wait_clk(12);
      check("short pulse run", 0, main_run);
      check("short pulse analog", 1, ana_en);
      register_write_cmd(ADDR_MODE0[4:0], 8'h14);
      i_host.set_pin(1'b0);
      wait_clk(PD + 20);
      check("pd analog", 0, ana_en);
      check("pd reference", 0, ref_en);
      check("pd dout driven", 0, dout);
      i_host.set_pin(1'b1);
      wait_clk(PD + 8);
      check("exit analog", 1, ana_en);
      check("exit delay", REG_DEF[3][3:0], delay);
   endtask

   initial
   begin
      sys_rst_in = 1'b1;
      raw_valid  = 1'b0;
      raw        = 32'h0;
      aux_valid  = 1'b0;
      aux_data   = 32'h0;
      cal_seen   = 6'h00;
      wait_clk(12);
      sys_rst_in <= 1'b0;
      wait_clk(4);
      t_reg_read;
      t_run_cmds;
      t_cal_cmds;
      t_chop;
      t_cmd_reset;
      t_pin;
      give_verdict;
   end

   initial
   begin
      #400000;
      err_total++;
      give_verdict;
   end
endmodule // test_adc_command_reset_chop_control
